// [shared/wiper_otp_defines.vh]
// constants for the wiper fuse-array store and protect block
// assumes one 40 MHz clock and a two-wire command link on pins
//
// Overview of operation
// R1: store copies wiper into next slot from 0x01
// R2: at most fifty successful stores ever
// R3: store lasts 350 ms, commands locked meanwhile
// R4: program success bit records last store outcome
// R5: blank array gives midscale wiper at power-up
// R6: slot read takes index from D5..D0
// R7: last-slot command returns newest written slot index
// R8: slot zero reserved, 0x01..0x32 hold stores in order
// R9: wiper and array writes refused after power-up
// R10: unlock bit 0 freezes wiper except reloads
// R11: host sets unlock bit before wiper writes
// R12: program enable resets 0, host sets it
// R13: word 0x1C03 sets unlock and program enable
// R14: word 0x0500 loads wiper 0x100 when unlocked
// R15: word 0x0800 reads wiper next frame
// R16: word 0x0C00 stores wiper into next slot
// R17: wiper readback word holds wiper in bits 9..0
// R18: word 0x1800 reads last slot index next frame
// R19: last slot index sits in bits 5..0
// R20: all-zero word is no-op, clocks out results; the code instead sets the answer word to 0x0000
// R21: word 0x1419 reads slot 0x19 next frame
// R22: word 0x2000 reads four control bits next frame
// R23: frame is 16 bits MSB first: 00,cmd4,data10
// R24: success bit 1 after good store, default 0
// R25: address not acknowledged during store cycle
// R26: full array ignores store, reports failure
// R27: store without program enable changes nothing
`ifndef WIPER_OTP_DEFINES_VH
`define WIPER_OTP_DEFINES_VH

// command field codes
`define CMD_NOP          4'h0
`define CMD_WR_WIPER     4'h1
`define CMD_RD_WIPER     4'h2
`define CMD_STORE        4'h3
`define CMD_SW_RESET     4'h4
`define CMD_RD_SLOT      4'h5
`define CMD_RD_LAST      4'h6
`define CMD_WR_CTRL      4'h7
`define CMD_RD_CTRL      4'h8

// command word layout
`define CMD_MSB          13
`define CMD_LSB          10
`define DATA_MSB         9
`define SLOT_IDX_MSB     5

// control bit positions
`define CTRL_PGM_EN_BIT  0
`define CTRL_UNLOCK_BIT  1
`define CTRL_CAL_DIS_BIT 2

// array geometry and reset values
`define WIPER_W          10
`define SLOT_W           6
`define SLOT_NONE        6'h00
`define SLOT_FIRST       6'h01
`define SLOT_LAST        6'h32
`define WIPER_MIDSCALE   10'h200

// store cycle timing
`define STORE_TIME_MS    350
`define CLK_FREQ_KHZ     40000
// 350 ms at 40 MHz, sized for the 24-bit store counter
`define STORE_CYCLES     24'd14000000

// link address, value arbitrary
`define DEFAULT_DEV_ADDR 7'h2c

`endif

// [design/fuse_slot_memory.v]
// fuse slot storage: one write port, one registered read port
// assumes the caller never rewrites a slot
`timescale 1ns/1ps
`default_nettype none
`include "wiper_otp_defines.vh"

module fuse_slot_memory (
  // clock
  input  wire                  clk_in,
  // write side
  input  wire                  wr_en_in,
  input  wire [`SLOT_W-1:0]    wr_addr_in,
  input  wire [`WIPER_W-1:0]   wr_data_in,
  // read side
  input  wire [`SLOT_W-1:0]    rd_addr_in,
  output reg  [`WIPER_W-1:0]   rd_data_out
);

  reg [`WIPER_W-1:0] slots [0:(1<<`SLOT_W)-1];

  always @(posedge clk_in) begin
    if (wr_en_in) begin
      slots[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= slots[rd_addr_in];
  end

endmodule
`default_nettype wire

// [design/wiper_otp_store_and_protect.v]
// wiper register, fuse slot store, control bits and two-wire command slave
// assumes scl/sda and the reset pin come from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
`include "wiper_otp_defines.vh"

module wiper_otp_store_and_protect #(
  parameter [23:0] STORE_CYCLES = `STORE_CYCLES,
  parameter [6:0]  DEV_ADDR     = `DEFAULT_DEV_ADDR
) (
  // clock and reset
  input  wire                ref_clk_in,
  input  wire                sys_rst_in,
  // link pins
  input  wire                scl_in,
  input  wire                sda_in,
  output reg                 sda_out,
  output reg                 sda_oe_out,
  // hardware reset pin, active low
  input  wire                reset_pin_n_in,
  // state
  output reg  [`WIPER_W-1:0] wiper_setting_out,
  output reg                 array_program_enable_out,
  output reg                 wiper_write_unlock_out,
  output reg                 cal_disable_out,
  output reg                 program_success_flag_out,
  output reg                 store_busy_out,
  output reg  [`SLOT_W-1:0]  last_slot_out
);

  localparam [23:0] STORE_END = STORE_CYCLES - 24'h000001;

  localparam [2:0] L_IDLE     = 3'd0;
  localparam [2:0] L_ADDR     = 3'd1;
  localparam [2:0] L_ADDR_ACK = 3'd2;
  localparam [2:0] L_WR_BYTE  = 3'd3;
  localparam [2:0] L_WR_ACK   = 3'd4;
  localparam [2:0] L_RD_BYTE  = 3'd5;
  localparam [2:0] L_RD_ACK   = 3'd6;

  localparam [1:0] P_NONE   = 2'd0;
  localparam [1:0] P_RELOAD = 2'd1;
  localparam [1:0] P_SLOT   = 2'd2;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  reg scl_s1, scl_s2, scl_s3;
  reg sda_s1, sda_s2, sda_s3;
  reg rst_s1, rst_s2, rst_s3;

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      rst_s1 <= 1'b1;
      rst_s2 <= 1'b1;
      rst_s3 <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      rst_s1 <= reset_pin_n_in;
      rst_s2 <= rst_s1;
      rst_s3 <= rst_s2;
    end
  end

  wire scl_rise  = scl_s2 & ~scl_s3;
  wire scl_fall  = ~scl_s2 & scl_s3;
  wire frm_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire frm_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  wire pin_reset = rst_s3 & ~rst_s2;

  //////////////////////////////////////////////////////////////////////////////
  // two-wire slave: address, two command bytes, or two answer bytes

  reg  [2:0]  link_state;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  rx_shift;
  reg  [15:0] tx_shift;
  reg  [7:0]  cmd_hi;
  reg         second_byte;
  reg         rw_bit;
  reg         master_ack;
  reg         cmd_valid;
  reg  [15:0] cmd_word;
  reg  [15:0] rd_word;

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      link_state  <= L_IDLE;
      bit_cnt     <= 4'h0;
      rx_shift    <= 8'h00;
      tx_shift    <= 16'h0000;
      cmd_hi      <= 8'h00;
      second_byte <= 1'b0;
      rw_bit      <= 1'b0;
      master_ack  <= 1'b0;
      cmd_valid   <= 1'b0;
      cmd_word    <= 16'h0000;
      sda_out     <= 1'b0;
      sda_oe_out  <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      if (frm_start) begin
        link_state  <= L_ADDR;
        bit_cnt     <= 4'h0;
        second_byte <= 1'b0;
        sda_oe_out  <= 1'b0;
      end else if (frm_stop) begin
        link_state <= L_IDLE;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        case (link_state)
          L_ADDR, L_WR_BYTE: begin
            rx_shift <= {rx_shift[6:0], sda_s2};  // [R23]
            bit_cnt  <= bit_cnt + 4'h1;
          end
          L_RD_ACK: begin
            master_ack <= ~sda_s2;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (link_state)
          L_ADDR: begin
            if (bit_cnt == 4'h8) begin
              // no acknowledge while a store cycle runs [R25]
              if (rx_shift[7:1] == DEV_ADDR && !store_busy_out) begin
                sda_oe_out <= 1'b1;
                rw_bit     <= rx_shift[0];
                tx_shift   <= rd_word;
                link_state <= L_ADDR_ACK;
              end else begin
                link_state <= L_IDLE;
              end
            end
          end
          L_ADDR_ACK: begin
            if (rw_bit) begin
              sda_oe_out <= ~tx_shift[15];
              tx_shift   <= {tx_shift[14:0], 1'b0};
              bit_cnt    <= 4'h1;
              link_state <= L_RD_BYTE;
            end else begin
              sda_oe_out <= 1'b0;
              bit_cnt    <= 4'h0;
              link_state <= L_WR_BYTE;
            end
          end
          L_WR_BYTE: begin
            if (bit_cnt == 4'h8) begin
              sda_oe_out <= 1'b1;
              link_state <= L_WR_ACK;
              if (!second_byte) begin
                cmd_hi <= rx_shift;
              end else begin
                cmd_word  <= {cmd_hi, rx_shift};  // [R23]
                cmd_valid <= 1'b1;
              end
            end
          end
          L_WR_ACK: begin
            sda_oe_out  <= 1'b0;
            bit_cnt     <= 4'h0;
            second_byte <= ~second_byte;
            link_state  <= L_WR_BYTE;
          end
          L_RD_BYTE: begin
            if (bit_cnt == 4'h8) begin
              sda_oe_out <= 1'b0;
              link_state <= L_RD_ACK;
            end else begin
              sda_oe_out <= ~tx_shift[15];
              tx_shift   <= {tx_shift[14:0], 1'b0};
              bit_cnt    <= bit_cnt + 4'h1;
            end
          end
          L_RD_ACK: begin
            if (master_ack && !second_byte) begin
              second_byte <= 1'b1;
              sda_oe_out  <= ~tx_shift[15];
              tx_shift    <= {tx_shift[14:0], 1'b0};
              bit_cnt     <= 4'h1;
              link_state  <= L_RD_BYTE;
            end else begin
              sda_oe_out <= 1'b0;
              link_state <= L_IDLE;
            end
          end
          default: begin
            link_state <= L_IDLE;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fuse slot array

  reg                 mem_we;
  reg  [`SLOT_W-1:0]  mem_waddr;
  reg  [`WIPER_W-1:0] mem_wdata;
  reg  [`SLOT_W-1:0]  mem_raddr;
  wire [`WIPER_W-1:0] mem_rdata;

  fuse_slot_memory u_slots (
    .clk_in      (ref_clk_in),
    .wr_en_in    (mem_we),
    .wr_addr_in  (mem_waddr),
    .wr_data_in  (mem_wdata),
    .rd_addr_in  (mem_raddr),
    .rd_data_out (mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // command execution

  wire [3:0]          cmd_code = cmd_word[`CMD_MSB:`CMD_LSB];
  wire [`WIPER_W-1:0] cmd_data = cmd_word[`DATA_MSB:0];
  wire [`SLOT_W-1:0]  cmd_slot = cmd_word[`SLOT_IDX_MSB:0];
  wire [`SLOT_W-1:0]  next_slot = last_slot_out + `SLOT_FIRST;

  reg [1:0]  pend_kind;
  reg [1:0]  stage_kind;
  reg        slot_ok;
  reg [23:0] busy_cnt;

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wiper_setting_out        <= `WIPER_MIDSCALE;  // [R5]
      array_program_enable_out <= 1'b0;             // [R12]
      wiper_write_unlock_out   <= 1'b0;             // [R9]
      cal_disable_out          <= 1'b0;
      program_success_flag_out <= 1'b0;             // [R24]
      store_busy_out           <= 1'b0;
      last_slot_out            <= `SLOT_NONE;
      busy_cnt                 <= 24'h000000;
      rd_word                  <= 16'h0000;
      mem_we                   <= 1'b0;
      mem_waddr                <= `SLOT_NONE;
      mem_wdata                <= `WIPER_MIDSCALE;
      mem_raddr                <= `SLOT_NONE;
      pend_kind                <= P_NONE;
      stage_kind               <= P_NONE;
      slot_ok                  <= 1'b0;
    end else begin
      mem_we     <= 1'b0;
      pend_kind  <= P_NONE;
      stage_kind <= pend_kind;
      if (store_busy_out) begin
        busy_cnt <= busy_cnt + 24'h000001;
        if (busy_cnt == STORE_END) begin
          store_busy_out           <= 1'b0;  // [R3]
          program_success_flag_out <= 1'b1;  // [R4] [R24]
        end
      end
      if (stage_kind == P_RELOAD) begin
        if (last_slot_out == `SLOT_NONE) begin
          wiper_setting_out <= `WIPER_MIDSCALE;  // [R5]
        end else begin
          wiper_setting_out <= mem_rdata;  // [R10]
        end
      end else if (stage_kind == P_SLOT) begin
        rd_word <= slot_ok ? {6'h00, mem_rdata} : 16'h0000;  // [R6] [R21]
      end
      if (pin_reset) begin
        array_program_enable_out <= 1'b0;
        wiper_write_unlock_out   <= 1'b0;
        cal_disable_out          <= 1'b0;
        mem_raddr                <= last_slot_out;
        pend_kind                <= P_RELOAD;  // [R10]
      end else if (cmd_valid && !store_busy_out) begin  // [R3]
        rd_word <= cmd_word;
        case (cmd_code)
          `CMD_NOP: begin
          end  // [R20]
          `CMD_WR_WIPER: begin
            if (wiper_write_unlock_out) begin
              wiper_setting_out <= cmd_data;  // [R10] [R14]
            end
          end
          `CMD_RD_WIPER: begin
            rd_word <= {6'h00, wiper_setting_out};  // [R15] [R17]
          end
          `CMD_STORE: begin
            if (array_program_enable_out) begin  // [R27]
              if (last_slot_out < `SLOT_LAST) begin  // [R2] [R26]
                mem_we                   <= 1'b1;  // [R1] [R16]
                mem_waddr                <= next_slot;  // [R8]
                mem_wdata                <= wiper_setting_out;
                last_slot_out            <= next_slot;
                store_busy_out           <= 1'b1;  // [R3]
                busy_cnt                 <= 24'h000000;
                program_success_flag_out <= 1'b0;
              end else begin
                program_success_flag_out <= 1'b0;  // [R26]
              end
            end
          end
          `CMD_SW_RESET: begin
            mem_raddr <= last_slot_out;
            pend_kind <= P_RELOAD;  // [R10]
          end
          `CMD_RD_SLOT: begin
            mem_raddr <= cmd_slot;  // [R6]
            slot_ok   <= (cmd_slot != `SLOT_NONE) && (cmd_slot <= last_slot_out);  // [R8]
            pend_kind <= P_SLOT;
          end
          `CMD_RD_LAST: begin
            rd_word <= {10'h000, last_slot_out};  // [R7] [R18] [R19]
          end
          `CMD_WR_CTRL: begin
            array_program_enable_out <= cmd_data[`CTRL_PGM_EN_BIT];  // [R12] [R13]
            wiper_write_unlock_out   <= cmd_data[`CTRL_UNLOCK_BIT];  // [R13]
            cal_disable_out          <= cmd_data[`CTRL_CAL_DIS_BIT];
          end
          `CMD_RD_CTRL: begin
            rd_word <= {12'h000, program_success_flag_out, cal_disable_out,
                        wiper_write_unlock_out, array_program_enable_out};  // [R22] [R4]
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// [verif/wiper_otp_sva.sv]
// checker for the wiper fuse-array store and protect block
// assumes it is bound to the design top and sees its ports only
`timescale 1ns/1ps
`default_nettype none
`include "wiper_otp_defines.vh"

module wiper_otp_sva #(
  parameter [23:0] STORE_CYCLES = 24'd200
) (
  // clock and reset
  input wire logic                ref_clk_in,
  input wire logic                sys_rst_in,
  // link and state
  input wire logic                sda_oe_out,
  input wire logic [`WIPER_W-1:0] wiper_setting_out,
  input wire logic                array_program_enable_out,
  input wire logic                wiper_write_unlock_out,
  input wire logic                program_success_flag_out,
  input wire logic                store_busy_out,
  input wire logic [`SLOT_W-1:0]  last_slot_out
);
  logic [23:0] busy_cycles;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  // cycles spent in the current store
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !store_busy_out)
      busy_cycles <= 24'h0;
    else
      busy_cycles <= busy_cycles + 24'h1;
  end

  ////////////////////////////////////////
  chk_busy_bound:
    assert property (store_busy_out |-> busy_cycles < STORE_CYCLES)
    else $error("store cycle runs too long");
  chk_busy_full:
    assert property ($fell(store_busy_out) |-> $past(busy_cycles) + 24'd1 == STORE_CYCLES)
    else $error("store cycle ended early");
  chk_busy_frozen:
    assert property (store_busy_out && $past(store_busy_out) |-> $stable(wiper_setting_out)
      && $stable({wiper_write_unlock_out, array_program_enable_out}))
    else $error("state changed during a store");
  chk_busy_silent:
    assert property (busy_cycles >= 24'd60 |-> !sda_oe_out)
    else $error("link answered during a store");
  chk_slot_step:
    assert property ($changed(last_slot_out) |-> last_slot_out == $past(last_slot_out) + 6'h01)
    else $error("slot pointer did not step by one");
  chk_slot_limit:
    assert property (last_slot_out <= `SLOT_LAST)
    else $error("slot pointer beyond the last slot");
  chk_store_gate:
    assert property ($rose(store_busy_out) |-> $past(array_program_enable_out)
      && $past(last_slot_out, 2) < `SLOT_LAST)
    else $error("store started while disabled or full");
  chk_success_low:
    assert property (store_busy_out && $past(store_busy_out) |-> !program_success_flag_out)
    else $error("success flag high during a store");
  chk_success_end:
    assert property ($fell(store_busy_out) |-> ##[0:1] program_success_flag_out)
    else $error("success flag not set after a store");
  chk_reset_values:
    assert property ($fell(sys_rst_in) |-> wiper_setting_out == `WIPER_MIDSCALE
      && !array_program_enable_out && !wiper_write_unlock_out
      && !program_success_flag_out && last_slot_out == `SLOT_NONE)
    else $error("wrong values after reset");
endmodule

bind wiper_otp_store_and_protect wiper_otp_sva #(.STORE_CYCLES(STORE_CYCLES)) i_wiper_otp_sva (
  .ref_clk_in, .sys_rst_in, .sda_oe_out, .wiper_setting_out, .array_program_enable_out,
  .wiper_write_unlock_out, .program_success_flag_out, .store_busy_out, .last_slot_out);
`default_nettype wire

// [verif/link_host_model.sv]
// two-wire bus controller model, open drain on the data wire
// assumes a pull-up on the data wire; sda_in is the resolved level
`timescale 1ns/1ps
`default_nettype none
`include "wiper_otp_defines.vh"

module link_host_model #(
  parameter [6:0] DEV_ADDR = `DEFAULT_DEV_ADDR
) (
  // resolved data wire
  input  wire logic sda_in,
  // controller drive
  output var  logic scl_out,
  output var  logic sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  ////////////////////////////////////////
  // data set mid low phase, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    #50 sda_oe_out = !b;
    #50 scl_out = 1'b1;
    #90 r = sda_in;
    #10 scl_out = 1'b0;
  endtask

  task automatic start_cond();
    #50 sda_oe_out = 1'b0;
    #50 scl_out = 1'b1;
    #50 sda_oe_out = 1'b1;
    #50 scl_out = 1'b0;
  endtask

  // clock stands high after the stop
  task automatic stop_cond();
    #50 sda_oe_out = 1'b1;
    #50 scl_out = 1'b1;
    #50 sda_oe_out = 1'b0;
    #100;
  endtask

  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(last, r);
    ack = !r;
  endtask

  // repeats start and address until answered or out of tries
  task automatic address(input logic rd, input int tries, output logic ack);
    logic [7:0] q;
    for (int n = 0; n < tries; n++) begin
      start_cond();
      xfer({DEV_ADDR, rd}, 1'b1, q, ack);
      if (ack)
        break;
      stop_cond();
    end
  endtask

  task automatic write_word(input logic [15:0] w, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    address(1'b0, 40, a0);
    xfer(w[15:8], 1'b1, q, a1);
    xfer(w[7:0], 1'b1, q, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  task automatic read_word(output logic [15:0] w);
    logic a;
    address(1'b1, 40, a);
    xfer(8'hff, 1'b0, w[15:8], a);
    xfer(8'hff, 1'b1, w[7:0], a);
    stop_cond();
  endtask
endmodule
`default_nettype wire

// [verif/wiper_otp_store_and_protect_tb.sv]
// self-checking bench for the wiper fuse-array store and protect block
// assumes the host model drives the link; the data wire has a pull-up
`timescale 1ns/1ps
`default_nettype none
`include "wiper_otp_defines.vh"
`define CHECK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  end \
end

module wiper_otp_store_and_protect_tb;
  logic                ref_clk_in;
  logic                sys_rst_in;
  logic                reset_pin_n_in;
  logic                scl;
  logic                host_oe;
  logic                sda_out;
  logic                sda_oe_out;
  logic [`WIPER_W-1:0] wiper;
  wire  [3:0]          ctrl;
  logic                busy;
  logic [`SLOT_W-1:0]  last_slot;
  logic [15:0]         got;
  logic                ok;
  logic                ack;
  int                  n_mismatch = 0;
  int                  samples_checked = 0;
  int                  cycles = 0;
  wire logic           sda_line = (sda_oe_out ? sda_out : 1'b1) & !host_oe;
  // command, answer, wiper after, control bits 3..0
  localparam logic [45:0] ROWS [18] = '{
    {16'h0500, 16'h0500, 10'h200, 4'h0},
    {16'h0c00, 16'h0c00, 10'h200, 4'h0},
    {16'h0800, 16'h0200, 10'h200, 4'h0},
    {16'h1800, 16'h0000, 10'h200, 4'h0},
    {16'h1c03, 16'h1c03, 10'h200, 4'h3},
    {16'h0500, 16'h0500, 10'h100, 4'h3},
    {16'h0800, 16'h0100, 10'h100, 4'h3},
    {16'h0c00, 16'h0c00, 10'h100, 4'hb},
    {16'h1800, 16'h0001, 10'h100, 4'hb},
    {16'h1401, 16'h0100, 10'h100, 4'hb},
    {16'h1400, 16'h0000, 10'h100, 4'hb},
    {16'h2000, 16'h000b, 10'h100, 4'hb},
    {16'h0513, 16'h0513, 10'h113, 4'hb},
    {16'h0000, 16'h0000, 10'h113, 4'hb},
    {16'h1000, 16'h1000, 10'h100, 4'hb},
    {16'h1c01, 16'h1c01, 10'h100, 4'h9},
    {16'h0577, 16'h0577, 10'h100, 4'h9},
    {16'h1c03, 16'h1c03, 10'h100, 4'hb}
  };

  wiper_otp_store_and_protect #(.STORE_CYCLES(24'd200)) i_wiper_otp_store_and_protect (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .reset_pin_n_in(reset_pin_n_in),
    .wiper_setting_out(wiper), .array_program_enable_out(ctrl[0]),
    .wiper_write_unlock_out(ctrl[1]), .cal_disable_out(ctrl[2]),
    .program_success_flag_out(ctrl[3]), .store_busy_out(busy), .last_slot_out(last_slot));

  link_host_model i_link_host_model (.sda_in(sda_line), .scl_out(scl), .sda_oe_out(host_oe));

  ////////////////////////////////////////
  task automatic print_verdict();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // command frame, then a read frame that fetches its answer
  task automatic query(input logic [15:0] cmd, input logic [15:0] exp);
    i_link_host_model.write_word(cmd, ok);
    i_link_host_model.read_word(got);
    @(negedge ref_clk_in);
    `CHECK(ok, 1'b1)
    `CHECK(got, exp)
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  ////////////////////////////////////////
  initial begin
    sys_rst_in = 1'b1;
    reset_pin_n_in = 1'b1;
    repeat (8) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    foreach (ROWS[i]) begin
      query(ROWS[i][45:30], ROWS[i][29:14]);
      `CHECK(wiper, ROWS[i][13:4])
      `CHECK(ctrl, ROWS[i][3:0])
    end
    // fill the array; slot n holds wiper value n for n = 2..50
    for (int s = 2; s <= 50; s++) begin
      query(16'h0400 | 16'(s), 16'h0400 | 16'(s));
      i_link_host_model.write_word(16'h0c00, ok);
      if (s == 2) begin
        `CHECK(busy, 1'b1)
        i_link_host_model.address(1'b0, 1, ack);
        if (ack)
          i_link_host_model.stop_cond();
        `CHECK(ack, 1'b0)
      end
    end
    query(16'h1419, 16'h0019);
    query(16'h1432, 16'h0032);
    query(16'h1800, 16'h0032);
    query(16'h0555, 16'h0555);
    query(16'h0c00, 16'h0c00);
    `CHECK({ctrl[3], last_slot, wiper}, {1'b0, 6'h32, 10'h155})
    // the stored-only control bit, then a control readback that shows it
    query(16'h1c07, 16'h1c07);
    `CHECK(ctrl, 4'h7)
    query(16'h2000, 16'h0007);
    // pin reset reloads the newest slot and relocks
    reset_pin_n_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    reset_pin_n_in = 1'b1;
    repeat (10) @(negedge ref_clk_in);
    `CHECK({ctrl, wiper}, {4'h0, 10'h032})
    query(16'h0500, 16'h0500);
    `CHECK(wiper, 10'h032)
    sys_rst_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    @(negedge ref_clk_in);
    `CHECK({wiper, last_slot, ctrl}, {10'h200, 6'h00, 4'h0})
    // software reload with a blank array falls back to midscale
    query(16'h1c03, 16'h1c03);
    query(16'h0500, 16'h0500);
    `CHECK(wiper, 10'h100)
    query(16'h1000, 16'h1000);
    `CHECK(wiper, 10'h200)
    print_verdict();
  end
endmodule
`default_nettype wire
